// [core/sfb_bank.sv]
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
// Function
// [R1] software touches only defined registers, as intended
// [R2] reserved bits written zero, read value undefined
// [R3] fixed-zero bits always read back zero
// [R4] fixed-one bits always read back one
// [R5] bit addressable registers reachable per bit
// [R6] eeprom control resets 0E with flag fields
// [R7] baud control resets 00, two control bits
// [R8] baud divisor bytes at BE/BF reset 00
// [R9] capcomp A/B control reset 00, full fields
// [R10] capcomp C/D control hold only bits 2:0
// [R11] comparator controls reset 00, six low bits
// [R12] cpu clock divider at 95, resets 00
// [R13] capture A/B byte pairs reset 00
// [R14] compare A bytes at EF/EE reset 00
// [R15] two-wire clock counts at DD/DC reset 00
// [R16] keypad mask at 86 resets 00
// [R17] group0 high priority mirrors group0, bit7 reserved
// [R18] group1 high priority mirrors group1, bit5 reserved
// [R19] all registers eight bits, synchronous reset
module sfb_bank (
	input wire logic clock,
	input wire logic rst,
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire sfb_pkg::sfb_hw_in_type hw_in,
	output sfb_pkg::sfb_ctrl_type ctrl_out,
	output logic irq
);
	import sfb_pkg::*;

	logic [7:0] bank_reg [BANK_DEPTH];
	logic [7:0] bank_next [BANK_DEPTH];
	logic wait_reg;
	logic [31:0] rdata_reg;
	logic [IRQ_WIDTH-1:0] irq_status_reg;
	logic [IRQ_WIDTH-1:0] irq_status_next;
	logic [IRQ_WIDTH-1:0] irq_mask_reg;
	logic [IRQ_WIDTH-1:0] irq_mask_next;
	logic [IRQ_WIDTH-1:0] irq_events;
	logic irq_reg;
	logic take;
	logic lane_write;
	logic [1:0] region;
	logic [7:0] sfr_addr;
	logic [6:0] slot;
	sfb_desc_type d_sel;
	logic mapped;
	logic bank_we;
	logic [7:0] sel_val;
	logic [7:0] sel_read;
	logic [7:0] wbyte;
	logic [7:0] rd_byte;
	sfb_desc_type slot_desc [BANK_DEPTH];

	// request completes at the edge where waitrequest is seen low
	assign take = (avs_read | avs_write) & ~wait_reg;
	assign lane_write = take & avs_write & avs_byteenable[0];
	assign region = avs_address[8:7];

	// in the bit view the owning register is the bit address with bits 2:0 cleared
	always_comb begin
		sfr_addr = {1'b1, avs_address[6:0]};
		if (region == REGION_BIT) begin
			sfr_addr[2:0] = 3'b000; // [R5]
		end
	end

	assign slot = sfr_addr[6:0];
	assign d_sel = sfb_desc(sfr_addr);
	assign sel_val = bank_reg[slot];
	// unimplemented and reserved bits read zero, fixed-one bits read one
	assign sel_read = (sel_val & d_sel.rmask) | d_sel.ones; // [R2] [R3] [R4]

	always_comb begin
		mapped = 1'b0;
		if (region == REGION_BYTE || region == REGION_BIT) begin
			mapped = d_sel.defined; // [R1]
		end else if (avs_address == IDX_IRQ_STATUS || avs_address == IDX_IRQ_MASK) begin
			mapped = 1'b1;
		end
	end

	assign bank_we = lane_write & mapped & (region == REGION_BYTE || region == REGION_BIT);

	// a bit write replaces one bit of the stored value
	always_comb begin
		wbyte = avs_writedata[7:0];
		if (region == REGION_BIT) begin
			wbyte = sel_val;
			wbyte[avs_address[2:0]] = avs_writedata[0]; // [R5]
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		if (mapped) begin
			if (region == REGION_BYTE) begin
				rd_byte = sel_read;
			end else if (region == REGION_BIT) begin
				rd_byte = {7'h00, sel_read[avs_address[2:0]]}; // [R5]
			end else if (avs_address == IDX_IRQ_STATUS) begin
				rd_byte = 8'(irq_status_reg);
			end else begin
				rd_byte = 8'(irq_mask_reg);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wait_reg <= 1'b1;
		end else if ((avs_read | avs_write) & wait_reg) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (avs_read & wait_reg) begin
			rdata_reg <= {24'h000000, rd_byte};
		end
	end

	// software write first, hardware updates after so a set beats a clear
	always_comb begin
		for (int i = 0; i < BANK_DEPTH; i++) begin
			bank_next[i] = bank_reg[i];
		end
		if (bank_we) begin
			// only writable bits store, reserved bits stay zero
			bank_next[slot] = (wbyte & d_sel.wmask) | (sel_val & ~d_sel.wmask); // [R2] [R10]
		end
		if (hw_in.capture_a_load) begin
			bank_next[A_CAPTURE_A_LOW[6:0]] = hw_in.capture_a_value[7:0]; // [R13]
			bank_next[A_CAPTURE_A_HIGH[6:0]] = hw_in.capture_a_value[15:8]; // [R13]
		end
		if (hw_in.capture_b_load) begin
			bank_next[A_CAPTURE_B_LOW[6:0]] = hw_in.capture_b_value[7:0]; // [R13]
			bank_next[A_CAPTURE_B_HIGH[6:0]] = hw_in.capture_b_value[15:8]; // [R13]
		end
		if (hw_in.two_wire_state_load) begin
			bank_next[A_TWO_WIRE_STATE_CODE[6:0]] = {hw_in.two_wire_state, 3'b000}; // [R3]
		end
		bank_next[A_COMPARATOR_ONE_CONTROL[6:0]][CMP_RESULT_BIT] = hw_in.cmp_one_result; // [R11]
		bank_next[A_COMPARATOR_TWO_CONTROL[6:0]][CMP_RESULT_BIT] = hw_in.cmp_two_result; // [R11]
		if (hw_in.cmp_one_change) begin
			bank_next[A_COMPARATOR_ONE_CONTROL[6:0]][CMP_FLAG_BIT] = 1'b1; // [R11]
		end
		if (hw_in.cmp_two_change) begin
			bank_next[A_COMPARATOR_TWO_CONTROL[6:0]][CMP_FLAG_BIT] = 1'b1; // [R11]
		end
		if (hw_in.eeprom_done) begin
			bank_next[A_EEPROM_CONTROL[6:0]][EEPROM_DONE_BIT] = 1'b1; // [R6]
		end
		if (hw_in.eeprom_error) begin
			bank_next[A_EEPROM_CONTROL[6:0]][EEPROM_ERROR_BIT] = 1'b1; // [R6]
		end
		if (hw_in.keypad_match) begin
			bank_next[A_KEYPAD_CONTROL[6:0]][KEYPAD_FLAG_BIT] = 1'b1;
		end
	end

	// constant descriptor table, one entry per slot; undefined slots reset to zero
	always_comb begin
		for (int i = 0; i < BANK_DEPTH; i++) begin
			slot_desc[i] = sfb_desc({1'b1, 7'(i)});
		end
	end

	always_ff @(posedge clock) begin
		for (int i = 0; i < BANK_DEPTH; i++) begin
			if (rst) begin
				bank_reg[i] <= slot_desc[i].rst; // [R19] [R6] [R7] [R8] [R9] [R12] [R16]
			end else begin
				bank_reg[i] <= bank_next[i];
			end
		end
	end

	always_comb begin
		irq_events = '0;
		irq_events[IRQ_UNMAPPED] = take & ~mapped; // [R1]
		irq_events[IRQ_EEPROM_DONE] = hw_in.eeprom_done;
		irq_events[IRQ_CMP_ONE] = hw_in.cmp_one_change;
		irq_events[IRQ_CMP_TWO] = hw_in.cmp_two_change;
		irq_events[IRQ_KEYPAD] = hw_in.keypad_match;
		irq_events[IRQ_CAPTURE_A] = hw_in.capture_a_load;
		irq_events[IRQ_CAPTURE_B] = hw_in.capture_b_load;
		irq_status_next = irq_status_reg;
		irq_mask_next = irq_mask_reg;
		if (lane_write && avs_address == IDX_IRQ_STATUS) begin
			irq_status_next = irq_status_reg & ~avs_writedata[IRQ_WIDTH-1:0];
		end
		if (lane_write && avs_address == IDX_IRQ_MASK) begin
			irq_mask_next = avs_writedata[IRQ_WIDTH-1:0];
		end
		irq_status_next = irq_status_next | irq_events;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_status_reg <= '0;
			irq_mask_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			irq_status_reg <= irq_status_next;
			irq_mask_reg <= irq_mask_next;
			irq_reg <= |(irq_status_next & irq_mask_next);
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;
	assign irq = irq_reg;

	// control image straight from the bank flops
	assign ctrl_out.data_pointer = {bank_reg[A_DATA_POINTER_HIGH[6:0]],
		bank_reg[A_DATA_POINTER_LOW[6:0]]};
	assign ctrl_out.keypad_irq_mask = bank_reg[A_KEYPAD_IRQ_MASK[6:0]];
	assign ctrl_out.keypad_match_pattern = bank_reg[A_KEYPAD_MATCH_PATTERN[6:0]];
	assign ctrl_out.keypad_control = bank_reg[A_KEYPAD_CONTROL[6:0]];
	assign ctrl_out.cpu_clock_divider = bank_reg[A_CPU_CLOCK_DIVIDER[6:0]];
	assign ctrl_out.auxiliary_function = bank_reg[A_AUXILIARY_FUNCTION[6:0]];
	assign ctrl_out.irq_enable_group0 = bank_reg[A_IRQ_ENABLE_GROUP0[6:0]];
	assign ctrl_out.irq_enable_group1 = bank_reg[A_IRQ_ENABLE_GROUP1[6:0]];
	assign ctrl_out.irq_priority_group0 = bank_reg[A_IRQ_PRIORITY_GROUP0[6:0]];
	assign ctrl_out.irq_priority_group0_high = bank_reg[A_IRQ_PRIORITY_GROUP0_HIGH[6:0]]; // [R17]
	assign ctrl_out.irq_priority_group1 = bank_reg[A_IRQ_PRIORITY_GROUP1[6:0]];
	assign ctrl_out.irq_priority_group1_high = bank_reg[A_IRQ_PRIORITY_GROUP1_HIGH[6:0]]; // [R18]
	assign ctrl_out.comparator_one_control = bank_reg[A_COMPARATOR_ONE_CONTROL[6:0]];
	assign ctrl_out.comparator_two_control = bank_reg[A_COMPARATOR_TWO_CONTROL[6:0]];
	assign ctrl_out.baud_generator_control = bank_reg[A_BAUD_GENERATOR_CONTROL[6:0]]; // [R7]
	assign ctrl_out.baud_divisor = {bank_reg[A_BAUD_DIVISOR_HIGH[6:0]],
		bank_reg[A_BAUD_DIVISOR_LOW[6:0]]}; // [R8]
	assign ctrl_out.two_wire_control = bank_reg[A_TWO_WIRE_CONTROL[6:0]];
	assign ctrl_out.two_wire_data = bank_reg[A_TWO_WIRE_DATA[6:0]];
	assign ctrl_out.two_wire_own_address = bank_reg[A_TWO_WIRE_OWN_ADDRESS[6:0]];
	assign ctrl_out.two_wire_clock_low_count = bank_reg[A_TWO_WIRE_CLOCK_LOW_COUNT[6:0]]; // [R15]
	assign ctrl_out.two_wire_clock_high_count = bank_reg[A_TWO_WIRE_CLOCK_HIGH_COUNT[6:0]]; // [R15]
	assign ctrl_out.accumulator = bank_reg[A_ACCUMULATOR[6:0]];
	assign ctrl_out.capcomp_a_control = bank_reg[A_CAPCOMP_A_CONTROL[6:0]]; // [R9]
	assign ctrl_out.capcomp_b_control = bank_reg[A_CAPCOMP_B_CONTROL[6:0]]; // [R9]
	assign ctrl_out.capcomp_c_control = bank_reg[A_CAPCOMP_C_CONTROL[6:0]]; // [R10]
	assign ctrl_out.capcomp_d_control = bank_reg[A_CAPCOMP_D_CONTROL[6:0]]; // [R10]
	assign ctrl_out.compare_a = {bank_reg[A_COMPARE_A_HIGH[6:0]],
		bank_reg[A_COMPARE_A_LOW[6:0]]}; // [R14]
	assign ctrl_out.multiply_divide_aux = bank_reg[A_MULTIPLY_DIVIDE_AUX[6:0]];
	// fixed-one bits load at reset and are never writable, so the flop already holds them
	assign ctrl_out.eeprom_control = bank_reg[A_EEPROM_CONTROL[6:0]]; // [R6] [R4]
	assign ctrl_out.eeprom_data = bank_reg[A_EEPROM_DATA[6:0]];
	assign ctrl_out.eeprom_address = bank_reg[A_EEPROM_ADDRESS[6:0]];
endmodule

// [inc/sfb_pkg.sv]
package sfb_pkg;
	// register addresses within the special register space
	localparam logic [7:0] A_DATA_POINTER_LOW = 8'h82, A_DATA_POINTER_HIGH = 8'h83,
		A_KEYPAD_IRQ_MASK = 8'h86, A_KEYPAD_MATCH_PATTERN = 8'h93,
		A_KEYPAD_CONTROL = 8'h94, A_CPU_CLOCK_DIVIDER = 8'h95,
		A_AUXILIARY_FUNCTION = 8'hA2, A_IRQ_ENABLE_GROUP0 = 8'hA8,
		A_CAPTURE_A_LOW = 8'hAA, A_CAPTURE_A_HIGH = 8'hAB,
		A_COMPARATOR_ONE_CONTROL = 8'hAC, A_COMPARATOR_TWO_CONTROL = 8'hAD,
		A_CAPTURE_B_LOW = 8'hAE, A_CAPTURE_B_HIGH = 8'hAF,
		A_IRQ_PRIORITY_GROUP0_HIGH = 8'hB7, A_IRQ_PRIORITY_GROUP0 = 8'hB8,
		A_BAUD_GENERATOR_CONTROL = 8'hBD, A_BAUD_DIVISOR_LOW = 8'hBE,
		A_BAUD_DIVISOR_HIGH = 8'hBF, A_TWO_WIRE_CONTROL = 8'hD8,
		A_TWO_WIRE_STATE_CODE = 8'hD9, A_TWO_WIRE_DATA = 8'hDA,
		A_TWO_WIRE_OWN_ADDRESS = 8'hDB, A_TWO_WIRE_CLOCK_LOW_COUNT = 8'hDC,
		A_TWO_WIRE_CLOCK_HIGH_COUNT = 8'hDD, A_ACCUMULATOR = 8'hE0,
		A_IRQ_ENABLE_GROUP1 = 8'hE8, A_CAPCOMP_A_CONTROL = 8'hEA,
		A_CAPCOMP_B_CONTROL = 8'hEB, A_CAPCOMP_C_CONTROL = 8'hEC,
		A_CAPCOMP_D_CONTROL = 8'hED, A_COMPARE_A_LOW = 8'hEE,
		A_COMPARE_A_HIGH = 8'hEF, A_MULTIPLY_DIVIDE_AUX = 8'hF0,
		A_EEPROM_CONTROL = 8'hF1, A_EEPROM_DATA = 8'hF2,
		A_EEPROM_ADDRESS = 8'hF3, A_IRQ_PRIORITY_GROUP1_HIGH = 8'hF7,
		A_IRQ_PRIORITY_GROUP1 = 8'hF8;
	localparam logic [7:0] RST_ZERO = 8'h00, RST_KEYPAD_PATTERN = 8'hFF,
		RST_EEPROM_CONTROL = 8'h0E, RST_TWO_WIRE_STATE = 8'hF8;
	// bus word index map: 0x080..0x0FF byte view, 0x180..0x1FF bit view
	localparam logic [1:0] REGION_BYTE = 2'b01, REGION_BIT = 2'b11;
	localparam logic [8:0] IDX_IRQ_STATUS = 9'h040, IDX_IRQ_MASK = 9'h041;
	localparam int BANK_DEPTH = 128;
	localparam int IRQ_WIDTH = 7;
	localparam int IRQ_UNMAPPED = 0, IRQ_EEPROM_DONE = 1, IRQ_CMP_ONE = 2,
		IRQ_CMP_TWO = 3, IRQ_KEYPAD = 4, IRQ_CAPTURE_A = 5, IRQ_CAPTURE_B = 6;
	localparam int EEPROM_DONE_BIT = 7, EEPROM_ERROR_BIT = 6;
	localparam int CMP_RESULT_BIT = 1, CMP_FLAG_BIT = 0, KEYPAD_FLAG_BIT = 0;

	typedef struct packed {
		logic defined;
		logic [7:0] wmask;
		logic [7:0] rmask;
		logic [7:0] ones;
		logic [7:0] rst;
	} sfb_desc_type;

	typedef struct packed {
		logic eeprom_done;
		logic eeprom_error;
		logic cmp_one_result;
		logic cmp_one_change;
		logic cmp_two_result;
		logic cmp_two_change;
		logic keypad_match;
		logic capture_a_load;
		logic [15:0] capture_a_value;
		logic capture_b_load;
		logic [15:0] capture_b_value;
		logic two_wire_state_load;
		logic [4:0] two_wire_state;
	} sfb_hw_in_type;

	typedef struct packed {
		logic [15:0] data_pointer;
		logic [7:0] keypad_irq_mask;
		logic [7:0] keypad_match_pattern;
		logic [7:0] keypad_control;
		logic [7:0] cpu_clock_divider;
		logic [7:0] auxiliary_function;
		logic [7:0] irq_enable_group0;
		logic [7:0] irq_enable_group1;
		logic [7:0] irq_priority_group0;
		logic [7:0] irq_priority_group0_high;
		logic [7:0] irq_priority_group1;
		logic [7:0] irq_priority_group1_high;
		logic [7:0] comparator_one_control;
		logic [7:0] comparator_two_control;
		logic [7:0] baud_generator_control;
		logic [15:0] baud_divisor;
		logic [7:0] two_wire_control;
		logic [7:0] two_wire_data;
		logic [7:0] two_wire_own_address;
		logic [7:0] two_wire_clock_low_count;
		logic [7:0] two_wire_clock_high_count;
		logic [7:0] accumulator;
		logic [7:0] capcomp_a_control;
		logic [7:0] capcomp_b_control;
		logic [7:0] capcomp_c_control;
		logic [7:0] capcomp_d_control;
		logic [15:0] compare_a;
		logic [7:0] multiply_divide_aux;
		logic [7:0] eeprom_control;
		logic [7:0] eeprom_data;
		logic [7:0] eeprom_address;
	} sfb_ctrl_type;

	// wmask: software writable, rmask: readable stored bits, ones: read as one
	function automatic sfb_desc_type sfb_desc(input logic [7:0] a);
		sfb_desc_type d;
		d = '{1'b1, 8'hFF, 8'hFF, 8'h00, RST_ZERO};
		case (a)
			A_DATA_POINTER_LOW, A_DATA_POINTER_HIGH, A_KEYPAD_IRQ_MASK,
			A_CPU_CLOCK_DIVIDER, A_IRQ_ENABLE_GROUP0, A_BAUD_DIVISOR_LOW,
			A_BAUD_DIVISOR_HIGH, A_TWO_WIRE_DATA, A_TWO_WIRE_OWN_ADDRESS,
			A_TWO_WIRE_CLOCK_LOW_COUNT, A_TWO_WIRE_CLOCK_HIGH_COUNT, A_ACCUMULATOR,
			A_CAPCOMP_A_CONTROL, A_CAPCOMP_B_CONTROL, A_COMPARE_A_LOW,
			A_COMPARE_A_HIGH, A_MULTIPLY_DIVIDE_AUX, A_EEPROM_DATA,
			A_EEPROM_ADDRESS: begin
				d.defined = 1'b1;
			end
			A_KEYPAD_MATCH_PATTERN: begin
				d.rst = RST_KEYPAD_PATTERN;
			end
			A_KEYPAD_CONTROL: begin
				d = '{1'b1, 8'h03, 8'h03, 8'h00, RST_ZERO};
			end
			A_AUXILIARY_FUNCTION: begin
				d = '{1'b1, 8'hF9, 8'hF9, 8'h00, RST_ZERO};
			end
			A_CAPTURE_A_LOW, A_CAPTURE_A_HIGH, A_CAPTURE_B_LOW, A_CAPTURE_B_HIGH: begin
				d.wmask = 8'h00;
			end
			A_COMPARATOR_ONE_CONTROL, A_COMPARATOR_TWO_CONTROL: begin
				d = '{1'b1, 8'h3D, 8'h3F, 8'h00, RST_ZERO};
			end
			A_IRQ_PRIORITY_GROUP0_HIGH, A_IRQ_PRIORITY_GROUP0: begin
				d = '{1'b1, 8'h7F, 8'h7F, 8'h00, RST_ZERO};
			end
			A_IRQ_ENABLE_GROUP1, A_IRQ_PRIORITY_GROUP1_HIGH, A_IRQ_PRIORITY_GROUP1: begin
				d = '{1'b1, 8'hDF, 8'hDF, 8'h00, RST_ZERO};
			end
			A_BAUD_GENERATOR_CONTROL: begin
				d = '{1'b1, 8'h03, 8'h03, 8'h00, RST_ZERO};
			end
			A_TWO_WIRE_CONTROL: begin
				d = '{1'b1, 8'h7D, 8'h7D, 8'h00, RST_ZERO};
			end
			A_TWO_WIRE_STATE_CODE: begin
				d = '{1'b1, 8'h00, 8'hF8, 8'h00, RST_TWO_WIRE_STATE};
			end
			A_CAPCOMP_C_CONTROL, A_CAPCOMP_D_CONTROL: begin
				d = '{1'b1, 8'h07, 8'h07, 8'h00, RST_ZERO};
			end
			A_EEPROM_CONTROL: begin
				d = '{1'b1, 8'hF1, 8'hF1, 8'h0E, RST_EEPROM_CONTROL};
			end
			default: begin
				d = '{1'b0, 8'h00, 8'h00, 8'h00, RST_ZERO};
			end
		endcase
		return d;
	endfunction
endpackage

// [testbench/sfb_bank_props.sv]
`timescale 1ns/1ps
module sfb_bank_props (
	input wire logic clock,
	input wire logic rst,
	input wire logic [8:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire sfb_pkg::sfb_hw_in_type hw_in,
	input wire sfb_pkg::sfb_ctrl_type ctrl_out,
	input wire logic irq
);
	import sfb_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	wire logic rd_done = avs_read && !avs_waitrequest;
	wire logic wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];

	a_reset_values: assert property ($fell(rst) |->
		ctrl_out.cpu_clock_divider == 8'h00 && ctrl_out.keypad_match_pattern == 8'hFF
		&& ctrl_out.eeprom_control == 8'h0E && !irq && avs_waitrequest)
		else $error("register image wrong after reset");
	a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("waitrequest low without a request");
	a_div_store: assert property (wr_done && avs_address == 9'h095 |=>
		ctrl_out.cpu_clock_divider == $past(avs_writedata[7:0]))
		else $error("clock divider write not stored");
	a_baud_store: assert property (wr_done && avs_address == 9'h0BE |=>
		ctrl_out.baud_divisor[7:0] == $past(avs_writedata[7:0]))
		else $error("baud divisor low write not stored");
	a_eeprom_ones: assert property (rd_done && avs_address == 9'h0F1 |->
		avs_readdata[3:1] == 3'h7)
		else $error("eeprom control fixed ones lost");
	a_fixed_zero: assert property (rd_done |->
		(avs_address != 9'h0D9 || avs_readdata[2:0] == 3'h0)
		&& (avs_address != 9'h0A2 || !avs_readdata[2]))
		else $error("fixed zero bit read as one");
	a_upper_zero: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
		else $error("read data wider than eight bits");
	a_reserved_ctl: assert property (ctrl_out.capcomp_c_control[7:3] == 5'h0
		&& ctrl_out.baud_generator_control[7:2] == 6'h0
		&& ctrl_out.comparator_one_control[7:6] == 2'h0)
		else $error("reserved control bit set");
	a_prio_reserved: assert property (!ctrl_out.irq_priority_group0_high[7]
		&& !ctrl_out.irq_priority_group1_high[5])
		else $error("reserved priority bit set");
	cover property (rd_done && avs_address[8]);
	cover property ($rose(irq));
	cover property (wr_done && avs_address == 9'h040);
endmodule

bind sfb_bank sfb_bank_props u_props (.clock(clock), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .hw_in(hw_in), .ctrl_out(ctrl_out), .irq(irq));

// [testbench/tb_sfb_bank.sv]
`timescale 1ns/1ps
module tb_sfb_bank;
	import sfb_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [8:0] avs_address = 9'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	sfb_hw_in_type hw_in = '0;
	sfb_ctrl_type ctrl_out;
	logic irq;
	logic [7:0] sh [128];
	logic [31:0] rdat;
	int error_cnt = 0;
	int samples_checked = 0;

	sfb_bank uut (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hw_in(hw_in),
		.ctrl_out(ctrl_out), .irq(irq));

	initial begin
		forever #5 clock = ~clock;
	end

	// software-writable bits per address; everything else holds its value
	function automatic logic [7:0] wm(input logic [7:0] a);
		case (a)
			8'h94, 8'hBD: return 8'h03;
			8'hA2: return 8'hF9;
			8'hAC, 8'hAD: return 8'h3D;
			8'hB7, 8'hB8: return 8'h7F;
			8'hE8, 8'hF7, 8'hF8: return 8'hDF;
			8'hD8: return 8'h7D;
			8'hEC, 8'hED: return 8'h07;
			8'hF1: return 8'hF1;
			8'h82, 8'h83, 8'h86, 8'h93, 8'h95, 8'hA8, 8'hBE, 8'hBF, 8'hDA, 8'hDB, 8'hDC,
			8'hDD, 8'hE0, 8'hEA, 8'hEB, 8'hEE, 8'hEF, 8'hF0, 8'hF2, 8'hF3: return 8'hFF;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic bitok(input logic [7:0] r);
		return r inside {8'hA8, 8'hB8, 8'hD8, 8'hE0, 8'hE8, 8'hF0, 8'hF8};
	endfunction

	// registers that exist in this bank; rand_op and check_all touch no other address
	function automatic logic defd(input logic [7:0] a);
		return wm(a) != 8'h00 || a inside {8'hAA, 8'hAB, 8'hAE, 8'hAF, 8'hD9};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d,
		input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0);
		rdat = avs_readdata;
		chk(32'(n), 32'h2);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic init_sh();
		foreach (sh[i]) sh[i] = 8'h00;
		sh[7'h13] = 8'hFF;
		sh[7'h71] = 8'h0E;
		sh[7'h59] = 8'hF8;
	endtask

	task automatic wr_sh(input logic [7:0] a, input logic [7:0] d);
		sh[a[6:0]] = (sh[a[6:0]] & ~wm(a)) | (d & wm(a));
	endtask

	task automatic check_all();
		for (int i = 0; i < 128; i++) begin
			if (!defd(8'h80 + 8'(i))) continue;
			bus(1'b0, 9'h080 + 9'(i), 8'h00, 4'hF);
			chk(rdat, {24'h0, sh[i]});
		end
		chk({16'h0, ctrl_out.baud_divisor}, {16'h0, sh[7'h3F], sh[7'h3E]});
		chk({16'h0, ctrl_out.compare_a}, {16'h0, sh[7'h6F], sh[7'h6E]});
		chk({24'h0, ctrl_out.eeprom_control}, {24'h0, sh[7'h71]});
		chk({24'h0, ctrl_out.cpu_clock_divider}, {24'h0, sh[7'h15]});
		chk({24'h0, ctrl_out.keypad_irq_mask}, {24'h0, sh[7'h06]});
		chk({24'h0, ctrl_out.irq_priority_group0_high}, {24'h0, sh[7'h37]});
		chk({24'h0, ctrl_out.irq_priority_group1_high}, {24'h0, sh[7'h77]});
		chk({24'h0, ctrl_out.capcomp_c_control}, {24'h0, sh[7'h6C]});
		chk({24'h0, ctrl_out.two_wire_clock_high_count}, {24'h0, sh[7'h5D]});
	endtask

	// byte or bit view write at random, then read back through the same view
	task automatic rand_op();
		logic [7:0] a, d, r, v;
		logic [3:0] be;
		do begin
			a = {1'b1, 7'($urandom)};
		end while (!defd(a));
		d = 8'($urandom);
		be = 4'($urandom);
		r = a & 8'hF8;
		if ($urandom % 2 == 0 || !bitok(r)) begin
			bus(1'b1, {1'b0, a}, d, be);
			if (be[0]) wr_sh(a, d);
			bus(1'b0, {1'b0, a}, 8'h00, 4'hF);
			chk(rdat, {24'h0, sh[a[6:0]]});
		end else begin
			v = sh[r[6:0]];
			v[a[2:0]] = d[0];
			bus(1'b1, {1'b1, a}, d, be);
			if (be[0] && bitok(r)) wr_sh(r, v);
			bus(1'b0, {1'b1, a}, 8'h00, 4'hF);
			chk(rdat, {31'h0, bitok(r) & sh[r[6:0]][a[2:0]]});
		end
	endtask

	// one-cycle peripheral event; mirror its side effect on the register image
	task automatic pulse(input int k, input logic [15:0] v);
		@(posedge clock);
		case (k)
			1: hw_in.eeprom_done <= 1'b1;
			2: hw_in.cmp_one_change <= 1'b1;
			3: hw_in.cmp_two_change <= 1'b1;
			4: hw_in.keypad_match <= 1'b1;
			5: {hw_in.capture_a_load, hw_in.capture_a_value} <= {1'b1, v};
			default: {hw_in.capture_b_load, hw_in.capture_b_value} <= {1'b1, v};
		endcase
		@(posedge clock);
		hw_in <= '0;
		case (k)
			1: sh[7'h71] = sh[7'h71] | 8'h80;
			2: sh[7'h2C] = sh[7'h2C] | 8'h01;
			3: sh[7'h2D] = sh[7'h2D] | 8'h01;
			4: sh[7'h14] = sh[7'h14] | 8'h01;
			5: {sh[7'h2B], sh[7'h2A]} = v;
			default: {sh[7'h2F], sh[7'h2E]} = v;
		endcase
	endtask

	task automatic irq_test();
		bus(1'b1, 9'h041, 8'h00, 4'h1);
		bus(1'b1, 9'h040, 8'h7F, 4'h1);
		for (int k = 0; k < 7; k++) begin
			if (k == 0) begin
				bus(1'b0, 9'h000, 8'h00, 4'hF);
				chk(rdat, 32'h0);
			end else begin
				pulse(k, 16'($urandom));
			end
			bus(1'b0, 9'h040, 8'h00, 4'hF);
			chk(rdat, 32'h1 << k);
			chk({31'h0, irq}, 32'h0);
			bus(1'b1, 9'h041, 8'h01 << k, 4'h1);
			bus(1'b0, 9'h040, 8'h00, 4'hF);
			chk({31'h0, irq}, 32'h1);
			bus(1'b1, 9'h040, 8'h01 << k, 4'h1);
			bus(1'b0, 9'h040, 8'h00, 4'hF);
			chk(rdat, 32'h0);
			chk({31'h0, irq}, 32'h0);
			bus(1'b1, 9'h041, 8'h00, 4'h1);
		end
	endtask

	initial begin
		void'($urandom(32'hF7F48648));
		init_sh();
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		check_all();
		$display("test reset values done");
		repeat (400) rand_op();
		check_all();
		$display("test random access done");
		irq_test();
		check_all();
		$display("test interrupts done");
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		init_sh();
		check_all();
		$display("test second reset done");
		test_done();
	end

	// run needs about 3000 cycles
	initial begin
		repeat (30000) @(posedge clock);
		error_cnt++;
		$display("Error at %0t: watchdog expired", $time);
		test_done();
	end
endmodule
